// File: core/reset_cause_tracker.sv
// Reset cause tracker: sticky cause flags, clear register and sequencer.
// Assumes rst_n is the power-on reset and all other inputs are synchronous.
//
// Contract
// - Four reset origins are told apart: pin, power-on, watchdog, software.
// - A readable and writable cause register records the latest reset origin; the code keeps every flag set since its last clear.
// - The clear register is eight bits, write only, bits mirror the cause.
// - A cause flag clears only when a one is written to its clear bit.
// - Cause bits seven to four are unused and always read as zero.
// - An external pin reset sets cause bit three.
// - Writing one to cause bit two starts a software reset, bit stays set.
// - A watchdog expiry reset sets cause bit one.
// - A power-on reset sets cause bit zero.
// - With bit two set, a clear write keeping bit two starts a reset.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

module reset_cause_tracker #(
   parameter int unsigned HOLD_CYCLES = reset_cause_pkg::HOLD_CYCLES,
   parameter int unsigned TIMER_W     = 8
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   input  wire reset_cause_pkg::bus_req_t     bus_req,
   output logic [reset_cause_pkg::DATA_W-1:0] rdata,
   input  wire logic                          ext_reset_n,
   input  wire logic                          wdt_expire,
   input  wire logic                          boot_done,
   output reset_cause_pkg::reset_ctl_t        reset_ctl,
   output logic [reset_cause_pkg::CAUSE_W-1:0] reset_cause
);

   typedef struct packed {
      reset_cause_pkg::seq_state_t        seq;
      logic [reset_cause_pkg::CAUSE_W-1:0] cause;
      logic [reset_cause_pkg::DATA_W-1:0]  rdata;
      reset_cause_pkg::reset_ctl_t         ctl;
   } top_state_t;

   localparam logic [reset_cause_pkg::CAUSE_W-1:0] POR_MASK =
      reset_cause_pkg::CAUSE_W'(1) << reset_cause_pkg::POR_BIT;
   localparam logic [reset_cause_pkg::CAUSE_W-1:0] WDT_MASK =
      reset_cause_pkg::CAUSE_W'(1) << reset_cause_pkg::WDT_BIT;
   localparam logic [reset_cause_pkg::CAUSE_W-1:0] SW_MASK =
      reset_cause_pkg::CAUSE_W'(1) << reset_cause_pkg::SW_BIT;
   localparam logic [reset_cause_pkg::CAUSE_W-1:0] EXT_MASK =
      reset_cause_pkg::CAUSE_W'(1) << reset_cause_pkg::EXT_BIT;

   top_state_t q;
   top_state_t d;

   logic                                 wr_cause;
   logic                                 wr_clear;
   logic                                 rd_cause;
   logic                                 rd_status;
   logic                                 sw_request;
   logic                                 trigger;
   logic                                 hold_expired;
   logic [reset_cause_pkg::CAUSE_W-1:0]  wr_byte;
   logic [reset_cause_pkg::CAUSE_W-1:0]  set_mask;
   logic [reset_cause_pkg::CAUSE_W-1:0]  clr_mask;
   logic [reset_cause_pkg::DATA_W-1:0]   status_word;

   // Address decode; a write or read elsewhere is simply ignored.
   assign wr_cause = bus_req.wr
      && (bus_req.addr == reset_cause_pkg::CAUSE_OFFSET);
   assign wr_clear = bus_req.wr
      && (bus_req.addr == reset_cause_pkg::CLEAR_OFFSET);
   assign rd_cause = bus_req.rd
      && (bus_req.addr == reset_cause_pkg::CAUSE_OFFSET);
   assign rd_status = bus_req.rd
      && (bus_req.addr == reset_cause_pkg::SEQ_STATUS_OFFSET);

   assign wr_byte = bus_req.wdata[reset_cause_pkg::CAUSE_W-1:0];

   // A software request comes either from setting the software bit directly
   // or from a clear write that leaves an already set software bit alone.
   always_comb begin
      sw_request = 1'b0;
      if (wr_cause && wr_byte[reset_cause_pkg::SW_BIT]) begin
         sw_request = 1'b1;
      end
      if (wr_clear && q.cause[reset_cause_pkg::SW_BIT]
          && !wr_byte[reset_cause_pkg::SW_BIT]) begin
         sw_request = 1'b1;
      end
   end

   // Each origin owns one bit, so the four can never be confused.
   always_comb begin
      set_mask = '0;
      if (!ext_reset_n) begin
         set_mask = set_mask | EXT_MASK;
      end
      if (wdt_expire) begin
         set_mask = set_mask | WDT_MASK;
      end
      if (sw_request) begin
         set_mask = set_mask | SW_MASK;
      end
   end

   // Only ones in the clear write remove flags; zeros leave them alone.
   always_comb begin
      clr_mask = '0;
      if (wr_clear) begin
         clr_mask = wr_byte & reset_cause_pkg::CAUSE_USED_MASK;
      end
   end

   assign trigger = (set_mask != '0);

   always_comb begin
      status_word = '0;
      status_word[reset_cause_pkg::STAT_IN_RESET_BIT] =
         (q.seq == reset_cause_pkg::SEQ_HOLD);
      status_word[reset_cause_pkg::STAT_BOOTING_BIT] =
         (q.seq == reset_cause_pkg::SEQ_BOOT);
      status_word[reset_cause_pkg::STAT_RAM_VALID_BIT] = q.ctl.ram_valid;
      status_word[reset_cause_pkg::STAT_WDT_HELD_BIT] = !q.ctl.wdt_rst_n;
   end

   hold_timer #(
      .WIDTH       (TIMER_W),
      .RESET_COUNT (HOLD_CYCLES)
   ) i_hold_timer (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (trigger),
      .expired (hold_expired)
   );

   always_comb begin
      d = q;
      d.ctl.boot_start = 1'b0;

      // Set wins over clear when both hit the same flag in one cycle, so a
      // reset event is never lost to a late clear from software.
      d.cause = ((q.cause & ~clr_mask) | set_mask)
         & reset_cause_pkg::CAUSE_USED_MASK;

      d.rdata = '0;
      if (rd_cause) begin
         d.rdata = {{(reset_cause_pkg::DATA_W - reset_cause_pkg::CAUSE_W)
            {1'b0}}, q.cause};
      end else if (rd_status) begin
         d.rdata = status_word;
      end

      case (q.seq)
         reset_cause_pkg::SEQ_HOLD: begin
            if (hold_expired && !trigger) begin
               d.seq = reset_cause_pkg::SEQ_BOOT;
               d.ctl.periph_rst_n = 1'b1;
               d.ctl.pin_default = 1'b0;
               d.ctl.wdt_rst_n = 1'b1;
               d.ctl.boot_start = 1'b1;
            end
         end
         reset_cause_pkg::SEQ_BOOT: begin
            if (boot_done) begin
               d.seq = reset_cause_pkg::SEQ_RUN;
            end
         end
         reset_cause_pkg::SEQ_RUN: begin
            d.seq = reset_cause_pkg::SEQ_RUN;
         end
         default: begin
            d.seq = reset_cause_pkg::SEQ_HOLD;
         end
      endcase

      // A new event restarts the hold from any state. The watchdog keeps
      // its present reset level, so only a power-on hold resets it.
      if (trigger) begin
         d.seq = reset_cause_pkg::SEQ_HOLD;
         d.ctl.periph_rst_n = 1'b0;
         d.ctl.pin_default = 1'b1;
         d.ctl.ram_valid = 1'b1;
      end
   end

   // The cause register is reset only by power-on, never by the system
   // reset it generates, which is what lets software read it after boot.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q.seq <= reset_cause_pkg::SEQ_HOLD;
         q.cause <= reset_cause_pkg::CAUSE_RESET;
         q.rdata <= '0;
         q.ctl.periph_rst_n <= 1'b0;
         q.ctl.pin_default <= 1'b1;
         q.ctl.wdt_rst_n <= 1'b0;
         q.ctl.boot_start <= 1'b0;
         q.ctl.ram_valid <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;
   assign reset_ctl = q.ctl;
   assign reset_cause = q.cause;

endmodule

// File: core/reset_cause_pkg.sv
// Shared constants and types for the reset cause tracker.
// Assumes a single 125 MHz system clock and a byte-addressed register port.
package reset_cause_pkg;

   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CAUSE_W = 8;

   localparam logic [31:0] CAUSE_OFFSET      = 32'hFFFF0230;
   localparam logic [31:0] CLEAR_OFFSET      = 32'hFFFF0234;
   localparam logic [31:0] SEQ_STATUS_OFFSET = 32'hFFFF0238;

   localparam int unsigned POR_BIT = 0;
   localparam int unsigned WDT_BIT = 1;
   localparam int unsigned SW_BIT  = 2;
   localparam int unsigned EXT_BIT = 3;

   localparam logic [7:0] CAUSE_USED_MASK = 8'h0F;
   localparam logic [7:0] CAUSE_RESET     = 8'h01;

   localparam int unsigned STAT_IN_RESET_BIT  = 0;
   localparam int unsigned STAT_BOOTING_BIT   = 1;
   localparam int unsigned STAT_RAM_VALID_BIT = 2;
   localparam int unsigned STAT_WDT_HELD_BIT  = 3;

   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned HOLD_TIME_NS  = 64;
   localparam int unsigned HOLD_CYCLES   =
      (HOLD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      SEQ_HOLD,
      SEQ_BOOT,
      SEQ_RUN
   } seq_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

   typedef struct packed {
      logic periph_rst_n;
      logic pin_default;
      logic wdt_rst_n;
      logic boot_start;
      logic ram_valid;
   } reset_ctl_t;

endpackage

// File: core/hold_timer.sv
// Down-counter that measures how long the system stays in reset.
// Assumes load is a synchronous request from the sequencer.
`timescale 1ns/1ps

module hold_timer #(
   parameter int unsigned WIDTH       = 8,
   parameter int unsigned RESET_COUNT = 8
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic load,
   output logic      expired
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             expired;
   } timer_state_t;

   localparam logic [WIDTH-1:0] LOAD_VALUE = WIDTH'(RESET_COUNT - 1);

   timer_state_t q;
   timer_state_t d;

   always_comb begin
      d = q;
      if (load) begin
         d.count = LOAD_VALUE;
         d.expired = 1'b0;
      end else if (q.count != '0) begin
         d.count = q.count - WIDTH'(1);
         d.expired = 1'b0;
      end else begin
         d.expired = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q.count <= LOAD_VALUE;
         q.expired <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign expired = q.expired;

endmodule

// File: verification/reset_cause_chk.sv
// Assertion checker for the reset cause tracker's ports.
// Assumes one clock domain and the package compiled first.
`timescale 1ns/1ps
module reset_cause_chk #(
   parameter int unsigned HOLD_CYCLES = 2
) (
   input wire logic                               sys_clk,
   input wire logic                               rst_n,
   input wire reset_cause_pkg::bus_req_t          bus_req,
   input wire logic [reset_cause_pkg::DATA_W-1:0] rdata,
   input wire logic                               ext_reset_n,
   input wire logic                               wdt_expire,
   input wire logic                               boot_done,
   input wire reset_cause_pkg::reset_ctl_t        reset_ctl,
   input wire logic [reset_cause_pkg::CAUSE_W-1:0] reset_cause
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Counts hold cycles; a bench never holds a source long enough to wrap it.
   logic [7:0] low_q;
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n) low_q <= 8'h00;
      else low_q <= reset_ctl.periph_rst_n ? 8'h00 : low_q + 8'h01;
   sequence s_clr_wr;
      bus_req.wr && bus_req.addr == reset_cause_pkg::CLEAR_OFFSET;
   endsequence
   sequence s_sw_req;
      bus_req.wr && bus_req.addr == reset_cause_pkg::CAUSE_OFFSET
         && bus_req.wdata[2];
   endsequence
   a_rd_cause: assert property (
      bus_req.rd && bus_req.addr == reset_cause_pkg::CAUSE_OFFSET
      |=> rdata == {24'h000000, $past(reset_cause)}) else $error("cause read");
   a_rd_clear: assert property (
      bus_req.rd && bus_req.addr == reset_cause_pkg::CLEAR_OFFSET
      |=> rdata == 32'h00000000) else $error("clear register read");
   a_hi_zero: assert property (
      rdata[31:4] == 28'h0000000 && reset_cause[7:4] == 4'h0)
      else $error("unused bits set");
   a_ext_set: assert property (
      !ext_reset_n |=> reset_cause[3] && !reset_ctl.periph_rst_n)
      else $error("pin reset missed");
   a_wdt_set: assert property (
      wdt_expire |=> reset_cause[1] && reset_ctl.pin_default)
      else $error("watchdog reset missed");
   a_sw_set: assert property (
      s_sw_req |=> reset_cause[2] && !reset_ctl.periph_rst_n)
      else $error("software reset missed");
   a_clr_rearm: assert property (
      s_clr_wr ##0 (!bus_req.wdata[2] && reset_cause[2])
      |=> !reset_ctl.periph_rst_n) else $error("rearm missed");
   a_clear_only: assert property (
      (|($past(reset_cause) & ~reset_cause)) |-> $past(bus_req.wr
      && bus_req.addr == reset_cause_pkg::CLEAR_OFFSET))
      else $error("flag lost without clear");
   a_wdt_kept: assert property (
      wdt_expire && reset_ctl.wdt_rst_n
      |=> reset_ctl.wdt_rst_n && reset_ctl.ram_valid)
      else $error("watchdog wrongly reset");
   a_hold_len: assert property (
      reset_ctl.boot_start |-> low_q >= HOLD_CYCLES && reset_ctl.periph_rst_n)
      else $error("hold too short");
endmodule
bind reset_cause_tracker reset_cause_chk #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
   .ext_reset_n(ext_reset_n), .wdt_expire(wdt_expire),
   .boot_done(boot_done), .reset_ctl(reset_ctl), .reset_cause(reset_cause));

// File: verification/reset_cause_tracker_tb.sv
// Self-checking bench for the reset cause tracker.
// Assumes package, design and checker are compiled before it.
`timescale 1ns/1ps
module reset_cause_tracker_tb;
   localparam logic [31:0] CA = reset_cause_pkg::CAUSE_OFFSET;
   localparam logic [31:0] CL = reset_cause_pkg::CLEAR_OFFSET;
   localparam logic [31:0] ST = reset_cause_pkg::SEQ_STATUS_OFFSET;
   logic                        sys_clk = 1'b0;
   logic                        rst_n = 1'b0;
   reset_cause_pkg::bus_req_t   bus_req = '0;
   logic [31:0]                 rdata;
   logic                        ext_reset_n = 1'b1;
   logic                        wdt_expire = 1'b0;
   logic                        boot_done = 1'b0;
   reset_cause_pkg::reset_ctl_t reset_ctl;
   logic [7:0]                  reset_cause;
   int                          mismatches = 0;
   int                          checks_done = 0;
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) boot_done <= reset_ctl.boot_start;
   reset_cause_tracker #(.HOLD_CYCLES(2)) i_reset_cause_tracker (
      .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
      .ext_reset_n(ext_reset_n), .wdt_expire(wdt_expire),
      .boot_done(boot_done), .reset_ctl(reset_ctl),
      .reset_cause(reset_cause));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge sys_clk) bus_req <= '{a, {24'h000000, d}, 1'b1, 1'b0};
      @(posedge sys_clk) bus_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      @(posedge sys_clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge sys_clk) bus_req.rd <= 1'b0;
      #1 check(rdata, {24'h000000, e});
   endtask
   // The ports show boot only as a pulse, so hold length is left to the checker.
   task automatic wait_boot();
      int n;
      n = 0;
      while (reset_ctl.boot_start !== 1'b1) begin
         @(posedge sys_clk) #1;
         n++;
         if (n > 100) begin
            mismatches++;
            give_verdict();
         end
      end
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic ctl(input logic [4:0] e);
      check({27'h0, reset_ctl}, {27'h0, e});
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      #1 ctl(5'h08);
      @(posedge sys_clk) rst_n <= 1'b1;
      wait_boot();
      ctl(5'h14);
      rd(CA, 8'h01);
      rd(CL, 8'h00);
      rd(32'hFFFF023C, 8'h00);
      rd(ST, 8'h00);
      wr(CL, 8'hFE);
      rd(CA, 8'h01);
      wr(CL, 8'h01);
      rd(CA, 8'h00);
      wr(CA, 8'hFB);
      rd(CA, 8'h00);
      @(posedge sys_clk) wdt_expire <= 1'b1;
      @(posedge sys_clk) wdt_expire <= 1'b0;
      #1 ctl(5'h0D);
      wait_boot();
      ctl(5'h15);
      rd(CA, 8'h02);
      rd(ST, 8'h04);
      @(posedge sys_clk) ext_reset_n <= 1'b0;
      rd(ST, 8'h05);
      @(posedge sys_clk) ext_reset_n <= 1'b1;
      #1 ctl(5'h0D);
      wait_boot();
      rd(CA, 8'h0A);
      wr(CA, 8'hF4);
      ctl(5'h0D);
      wait_boot();
      rd(CA, 8'h0E);
      wr(CL, 8'h08);
      ctl(5'h0D);
      wait_boot();
      rd(CA, 8'h06);
      // Clear and watchdog hit bit one in one cycle, so the set must win.
      fork
         wr(CL, 8'h02);
         begin
            @(posedge sys_clk) wdt_expire <= 1'b1;
            @(posedge sys_clk) wdt_expire <= 1'b0;
         end
      join
      ctl(5'h0D);
      wait_boot();
      rd(CA, 8'h06);
      wr(CL, 8'h06);
      ctl(5'h15);
      rd(CA, 8'h00);
      @(posedge sys_clk) rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 ctl(5'h08);
      @(posedge sys_clk) rst_n <= 1'b1;
      wait_boot();
      ctl(5'h14);
      rd(CA, 8'h01);
      give_verdict();
   end
endmodule
